// *** hw/scc_defines.svh ***
// Offsets, field positions, reset values and divider ratios of the clock control block
`ifndef SCC_DEFINES_SVH
`define SCC_DEFINES_SVH

`define SCC_AW                 16
`define SCC_OFS_CTRL0          16'h0006
`define SCC_OFS_CTRL1          16'h0007
`define SCC_OFS_PROTECT        16'h000A
`define SCC_OFS_DETECT         16'h000C
`define SCC_OFS_MODE2          16'h001E

`define SCC_RST_CTRL0          8'h48
`define SCC_RST_CTRL1          8'h20
`define SCC_RST_DETECT         8'h00
`define SCC_RST_PROTECT        8'h00
`define SCC_RST_MODE2          8'h00

// Control 0 fields
`define SCC_B_CLKOUT_LO        0
`define SCC_B_CLKOUT_HI        1
`define SCC_B_WAIT_STOP        2
`define SCC_B_SUB_DRIVE        3
`define SCC_B_SUB_PORT         4
`define SCC_B_MAIN_STOP        5
`define SCC_B_DIV8             6
`define SCC_B_SUB_SEL          7
// Control 1 fields
`define SCC_B_ALL_STOP         0
`define SCC_B_PLL_SEL          1
`define SCC_B_MAIN_DRIVE       5
`define SCC_B_DIVF_LO          6
`define SCC_B_DIVF_HI          7
// Detection register fields
`define SCC_B_DET_EN           0
`define SCC_B_ONCHIP_SEL       1
`define SCC_B_DET_FLAG         2
`define SCC_B_MON_FLAG         3
`define SCC_B_DET_ACTION       7
`define SCC_DETECT_RW_MASK     8'hB3
// Protect and mode 2 fields
`define SCC_B_WR_EN            0
`define SCC_B_LOCK             1
`define SCC_B_WDT_SRC          2

// Divider tap indices: /2 /4 /8 /16 /32
`define SCC_NTAP               5
`define SCC_TAP_DIV2           0
`define SCC_TAP_DIV4           1
`define SCC_TAP_DIV8           2
`define SCC_TAP_DIV16          3
`define SCC_TAP_DIV32          4

`endif

// *** hw/scc_pkg.sv ***
// Types shared by the clock control block
package scc_pkg;
    typedef enum logic [1:0] {
        SCC_SRC_MAIN,
        SCC_SRC_PLL,
        SCC_SRC_ONCHIP,
        SCC_SRC_SUB
    } scc_src_t;

    typedef enum logic [1:0] {
        SCC_CKO_PORT,
        SCC_CKO_SUB,
        SCC_CKO_DIV8,
        SCC_CKO_DIV32
    } scc_cko_t;
endpackage

// *** hw/scc_div_if.sv ***
// Carrier between the prescaler and the control block
`timescale 1ns/1ps
`default_nettype none
`include "scc_defines.svh"
interface scc_div_if;
    logic                  run;
    logic [`SCC_NTAP-1:0]  tap_en;
    logic [`SCC_NTAP-1:0]  tap_lvl;
    modport ctrl (output run, input tap_en, input tap_lvl);
    modport div  (input run, output tap_en, output tap_lvl);
endinterface
`default_nettype wire

// *** hw/scc_div.sv ***
// Binary prescaler giving one-cycle enables and square levels
`timescale 1ns/1ps
`default_nettype none
`include "scc_defines.svh"
module scc_div
    import scc_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Taps
    scc_div_if.div    dv
);
    logic [`SCC_NTAP-1:0] cnt_q;
    logic [`SCC_NTAP-1:0] cnt_d;

    // Halts while stopped so no edges reach the peripherals
    assign cnt_d = dv.run ? cnt_q + `SCC_NTAP'(1) : cnt_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    genvar i;
    generate
        for (i = 0; i < `SCC_NTAP; i++) begin : g_tap
            assign dv.tap_en[i] = dv.run && (cnt_q[i:0] == {(i + 1){1'b1}});
        end
    endgenerate

    assign dv.tap_lvl = cnt_q;
endmodule
`default_nettype wire

// *** hw/scc_top.sv ***
// System clock control registers with oscillation stop detection
// Function
// - Wait-stop bit gates peripheral clocks in wait; sub /32 keeps running.
// - Sub drive bit forced high while port select is 0 or on stop.
// - Sub port select: 0 pins are I/O, 1 pins are sub oscillator.
// - Main stop bit halts main oscillator, output pin high, feedback kept.
// - Div8 bit: 1 divide by 8, 0 uses field; set on stop entry unless sub selected.
// - Sub select bit picks sub clock; else main, PLL or on-chip.
// - Control registers writable only after protect write enable is 1.
// - Lock bit ignores writes to wait, main stop, sub, all-stop, PLL bits.
// - Watchdog on-chip source bit ignores writes to all-stop bit.
// - On-chip off and main stopped holds div8 and main drive at 1.
// - Main drive forced high on stop from high/middle or main stop low-speed.
// - All-stop bit enters stop: clocks halt, main out high, sub pins float.
// - PLL select takes effect only with sub and on-chip selects clear.
// - Divider field 00 none, 01 /2, 10 /4, 11 /16 when div8 is 0.
// - Stop detected: interrupt (reset if action bit 0), flag and monitor set; on-chip select kept with PLL or sub as source.
// - Restart detected: interrupt (reset if action bit 0), flag set, monitor cleared.
// - Interrupt only on flag 0 to 1; flag cleared by writing 0 only.
// - Stop detected with main as CPU source and action bit 1 sets on-chip select.
`timescale 1ns/1ps
`default_nettype none
`include "scc_defines.svh"
module scc_top
    import scc_pkg::*;
(
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    // Register port
    input  wire logic [`SCC_AW-1:0]   reg_addr,
    input  wire logic [7:0]           reg_wdata,
    input  wire logic                 reg_we,
    input  wire logic                 reg_re,
    output logic      [7:0]           reg_rdata,
    // Chip state
    input  wire logic                 single_chip_mode,
    input  wire logic                 wait_mode,
    input  wire logic                 main_osc_alive,
    input  wire logic                 sub_clock_in,
    input  wire logic                 stop_wake,
    // Clock output pin
    output logic                      clkout_port_pin_o,
    output logic                      clkout_port_pin_oe,
    // Oscillator pins
    output logic                      main_osc_out_hold_high,
    output logic                      main_osc_feedback_en,
    output logic                      main_osc_run,
    output logic                      sub_osc_pins_osc,
    output logic                      sub_osc_pins_float,
    output logic                      sub_osc_drive_high,
    output logic                      main_osc_drive_high,
    // Clock tree control
    output scc_src_t                  sysclk_src,
    output logic                      cpu_clk_en,
    output logic                      periph_clk_run,
    output logic                      sub_clock_div32_run,
    output logic                      stop_mode,
    // Detection events
    output logic                      detect_irq,
    output logic                      detect_reset
);
    ////////////////////////////////////////////////////////////////////////////////
    logic [7:0] ctrl0_q, ctrl0_d, ctrl1_q, ctrl1_d, det_q, det_d;
    logic [7:0] prot_q, prot_d, mode2_q, mode2_d;
    logic [7:0] rdata_d;
    logic [2:0] alive_q, wake_q;
    logic [1:0] sub_q;

    scc_div_if dvi ();

    scc_div u_div (
        .clk (clk),
        .rst (rst),
        .dv  (dvi.div)
    );

    // Oscillator and wake levels pass three flops, sub clock two; edge logic reads only the later stages
    always_ff @(posedge clk) begin
        if (rst) begin
            // Oscillator taken as running, so no false return edge after reset
            alive_q <= '1;
            wake_q  <= '0;
            sub_q   <= '0;
        end else begin
            alive_q <= {alive_q[1:0], main_osc_alive};
            wake_q  <= {wake_q[1:0], stop_wake};
            sub_q   <= {sub_q[0], sub_clock_in};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    wire sel_ctrl0 = reg_addr == `SCC_OFS_CTRL0;
    wire sel_ctrl1 = reg_addr == `SCC_OFS_CTRL1;
    wire sel_det   = reg_addr == `SCC_OFS_DETECT;
    wire sel_prot  = reg_addr == `SCC_OFS_PROTECT;
    wire sel_mode2 = reg_addr == `SCC_OFS_MODE2;
    wire wr_open   = prot_q[`SCC_B_WR_EN];
    wire wr_ctrl0  = reg_we && sel_ctrl0 && wr_open;
    wire wr_ctrl1  = reg_we && sel_ctrl1 && wr_open;
    wire wr_det    = reg_we && sel_det && wr_open;
    wire lock      = mode2_q[`SCC_B_LOCK];
    wire wdt_src   = mode2_q[`SCC_B_WDT_SRC];

    // Bits that ignore writes while locked
    wire [7:0] keep0 = lock ? 8'hA4 : 8'h00;
    // Watchdog source choice pins the all-stop bit as well
    wire [7:0] keep1 = {6'h00, lock, lock | wdt_src};
    wire [7:0] keepd = lock ? 8'h01 : 8'h00;

    wire sub_sel    = ctrl0_q[`SCC_B_SUB_SEL];
    wire onchip_sel = det_q[`SCC_B_ONCHIP_SEL];
    wire pll_sel    = ctrl1_q[`SCC_B_PLL_SEL];
    wire stopped    = ctrl1_q[`SCC_B_ALL_STOP];

    // Stop entry is the all-stop bit going from 0 to 1
    wire stop_enter = wr_ctrl1 && !keep1[`SCC_B_ALL_STOP]
                      && reg_wdata[`SCC_B_ALL_STOP] && !stopped;
    wire wake_rise  = wake_q[1] && !wake_q[2];

    // Main clock loss and return seen only while detection is on
    wire det_en     = det_q[`SCC_B_DET_EN];
    wire osc_lost   = det_en && alive_q[2] && !alive_q[1];
    wire osc_back   = det_en && !alive_q[2] && alive_q[1] && det_q[`SCC_B_MON_FLAG];
    wire det_event  = osc_lost || osc_back;
    wire det_action = det_q[`SCC_B_DET_ACTION];
    // A set flag masks further interrupts until software writes 0
    wire irq_fire   = det_event && det_action && !det_q[`SCC_B_DET_FLAG];

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        ctrl0_d = wr_ctrl0 ? ((reg_wdata & ~keep0) | (ctrl0_q & keep0)) : ctrl0_q;
        ctrl1_d = wr_ctrl1 ? ((reg_wdata & ~keep1) | (ctrl1_q & keep1)) : ctrl1_q;
        det_d   = det_q;
        prot_d  = (reg_we && sel_prot) ? reg_wdata : prot_q;
        mode2_d = (reg_we && sel_mode2) ? reg_wdata : mode2_q;

        if (wr_det) begin
            det_d[`SCC_B_DET_EN]     = keepd[0] ? det_q[`SCC_B_DET_EN]
                                                : reg_wdata[`SCC_B_DET_EN];
            det_d[`SCC_B_ONCHIP_SEL] = reg_wdata[`SCC_B_ONCHIP_SEL];
            det_d[5:4]               = reg_wdata[5:4];
            det_d[`SCC_B_DET_ACTION] = reg_wdata[`SCC_B_DET_ACTION];
            // Only a written 0 clears the flag
            if (!reg_wdata[`SCC_B_DET_FLAG]) begin
                det_d[`SCC_B_DET_FLAG] = 1'b0;
            end
        end

        // Detection events win over a software clear in the same cycle
        if (det_event) begin
            det_d[`SCC_B_DET_FLAG] = 1'b1;
        end
        if (osc_lost) begin
            det_d[`SCC_B_MON_FLAG] = 1'b1;
            // PLL as source leaves on-chip select untouched
            if (det_action && !pll_sel && !sub_sel) begin
                det_d[`SCC_B_ONCHIP_SEL] = 1'b1;
            end
        end
        if (osc_back) begin
            det_d[`SCC_B_MON_FLAG] = 1'b0;
        end

        if (stop_enter) begin
            ctrl0_d[`SCC_B_SUB_DRIVE] = 1'b1;
            if (!sub_sel) begin
                ctrl0_d[`SCC_B_DIV8] = 1'b1;
            end
            if (!sub_sel && !onchip_sel) begin
                ctrl1_d[`SCC_B_MAIN_DRIVE] = 1'b1;
            end
        end
        // Held bits act on the next value, so no write can undo them
        if (!ctrl0_d[`SCC_B_SUB_PORT]) begin
            ctrl0_d[`SCC_B_SUB_DRIVE] = 1'b1;
        end
        if (ctrl0_d[`SCC_B_MAIN_STOP] && ctrl0_d[`SCC_B_SUB_SEL]) begin
            ctrl1_d[`SCC_B_MAIN_DRIVE] = 1'b1;
        end
        if (!det_d[`SCC_B_ONCHIP_SEL] && ctrl0_d[`SCC_B_MAIN_STOP]) begin
            ctrl0_d[`SCC_B_DIV8]       = 1'b1;
            ctrl1_d[`SCC_B_MAIN_DRIVE] = 1'b1;
        end
        // Stop is left by a wake event or by a write of 0 to the all-stop bit
        if (stopped && wake_rise) begin
            ctrl1_d[`SCC_B_ALL_STOP] = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl0_q <= `SCC_RST_CTRL0;
            ctrl1_q <= `SCC_RST_CTRL1;
            det_q   <= `SCC_RST_DETECT;
            prot_q  <= `SCC_RST_PROTECT;
            mode2_q <= `SCC_RST_MODE2;
        end else begin
            ctrl0_q <= ctrl0_d;
            ctrl1_q <= ctrl1_d;
            det_q   <= det_d;
            prot_q  <= prot_d;
            mode2_q <= mode2_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read mux; unmapped addresses read zero
    // Detection bit 6 reads 0; the monitor flag cannot be written
    always_comb begin
        rdata_d = 8'h00;
        if (sel_ctrl0) begin
            rdata_d = ctrl0_q;
        end else if (sel_ctrl1) begin
            rdata_d = ctrl1_q;
        end else if (sel_det) begin
            rdata_d = det_q & (`SCC_DETECT_RW_MASK | 8'h0C);
        end else if (sel_prot) begin
            rdata_d = prot_q;
        end else if (sel_mode2) begin
            rdata_d = mode2_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    scc_src_t src_d;
    assign src_d = sub_sel    ? SCC_SRC_SUB :
                   onchip_sel ? SCC_SRC_ONCHIP :
                   pll_sel    ? SCC_SRC_PLL : SCC_SRC_MAIN;

    wire [1:0] div_field = ctrl1_q[`SCC_B_DIVF_HI:`SCC_B_DIVF_LO];
    logic cpu_en_d;
    assign cpu_en_d = stopped ? 1'b0 :
        ctrl0_q[`SCC_B_DIV8] ? dvi.tap_en[`SCC_TAP_DIV8] :
        (div_field == 2'h0) ? 1'b1 :
        (div_field == 2'h1) ? dvi.tap_en[`SCC_TAP_DIV2] :
        (div_field == 2'h2) ? dvi.tap_en[`SCC_TAP_DIV4] :
                              dvi.tap_en[`SCC_TAP_DIV16];
    // Prescaler halts in stop so no derived enable leaks out
    assign dvi.run = !stopped;

    scc_cko_t cko;
    assign cko = scc_cko_t'(ctrl0_q[`SCC_B_CLKOUT_HI:`SCC_B_CLKOUT_LO]);
    logic cko_lvl;
    always_comb begin
        unique case (cko)
            SCC_CKO_PORT:  cko_lvl = 1'b0;
            SCC_CKO_SUB:   cko_lvl = sub_q[1];
            SCC_CKO_DIV8:  cko_lvl = dvi.tap_lvl[`SCC_TAP_DIV8];
            SCC_CKO_DIV32: cko_lvl = dvi.tap_lvl[`SCC_TAP_DIV32];
        endcase
    end

    // All pin and tree outputs come from flops
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata              <= 8'h00;
            clkout_port_pin_o      <= 1'b0;
            clkout_port_pin_oe     <= 1'b0;
            main_osc_out_hold_high <= 1'b0;
            main_osc_feedback_en   <= 1'b1;
            main_osc_run           <= 1'b1;
            sub_osc_pins_osc       <= 1'b0;
            sub_osc_pins_float     <= 1'b0;
            sub_osc_drive_high     <= 1'b1;
            main_osc_drive_high    <= 1'b1;
            sysclk_src             <= SCC_SRC_MAIN;
            cpu_clk_en             <= 1'b0;
            periph_clk_run         <= 1'b1;
            sub_clock_div32_run    <= 1'b1;
            stop_mode              <= 1'b0;
            detect_irq             <= 1'b0;
            detect_reset           <= 1'b0;
        end else begin
            reg_rdata              <= reg_re ? rdata_d : 8'h00;
            clkout_port_pin_o      <= cko_lvl;
            clkout_port_pin_oe     <= single_chip_mode && (cko != SCC_CKO_PORT);
            main_osc_out_hold_high <= ctrl0_q[`SCC_B_MAIN_STOP] || stopped;
            main_osc_feedback_en   <= !stopped;
            main_osc_run           <= !ctrl0_q[`SCC_B_MAIN_STOP] && !stopped;
            sub_osc_pins_osc       <= ctrl0_q[`SCC_B_SUB_PORT] && !stopped;
            sub_osc_pins_float     <= ctrl0_q[`SCC_B_SUB_PORT] && stopped;
            sub_osc_drive_high     <= ctrl0_q[`SCC_B_SUB_DRIVE];
            main_osc_drive_high    <= ctrl1_q[`SCC_B_MAIN_DRIVE];
            sysclk_src             <= src_d;
            cpu_clk_en             <= cpu_en_d;
            // Divided sub clock stays up in wait to keep timekeeping alive
            periph_clk_run         <= !stopped
                && !(wait_mode && ctrl0_q[`SCC_B_WAIT_STOP]);
            sub_clock_div32_run    <= !stopped;
            stop_mode              <= stopped;
            detect_irq             <= irq_fire;
            detect_reset           <= det_event && !det_action;
        end
    end
endmodule
`default_nettype wire

// *** tb/scc_top_chk.sv ***
// Port-level checker for the system clock control block
`timescale 1ns/1ps
`default_nettype none
module scc_top_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Chip state
    input wire logic single_chip_mode,
    input wire logic wait_mode,
    // Pins and clock tree
    input wire logic clkout_port_pin_oe,
    input wire logic main_osc_out_hold_high,
    input wire logic main_osc_feedback_en,
    input wire logic main_osc_run,
    input wire logic sub_osc_pins_osc,
    input wire logic sub_osc_drive_high,
    input wire logic cpu_clk_en,
    input wire logic periph_clk_run,
    input wire logic sub_clock_div32_run,
    input wire logic stop_mode,
    // Detection events
    input wire logic detect_irq,
    input wire logic detect_reset
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////////
    // Repeated antecedents leave room for one register stage of latency
    a_cko_off: assert property (!single_chip_mode [*2] |-> !clkout_port_pin_oe)
        else $error("clock output pin driven outside single-chip mode");
    a_periph_runs: assert property ((!wait_mode && !stop_mode) [*3] |-> periph_clk_run)
        else $error("peripheral clock gated outside wait");
    a_sub32_runs: assert property (!stop_mode [*2] |-> sub_clock_div32_run)
        else $error("sub clock divided by 32 stopped outside stop mode");
    a_sub_drive_forced: assert property (!sub_osc_pins_osc [*2] ##0 !stop_mode |-> sub_osc_drive_high)
        else $error("sub drive low while sub pins are ports");
    a_main_pin_held: assert property (main_osc_out_hold_high |-> !main_osc_run)
        else $error("main oscillator runs while its output is held");
    a_feedback_kept: assert property (!stop_mode [*2] |-> main_osc_feedback_en)
        else $error("feedback cut outside stop mode");
    a_stop_all_off: assert property (stop_mode [*2] |-> main_osc_out_hold_high
        && !main_osc_feedback_en && !main_osc_run && !cpu_clk_en)
        else $error("clocks or main pins active in stop mode");
    a_stop_no_osc: assert property (stop_mode [*2] |-> !sub_osc_pins_osc)
        else $error("sub oscillator pins active in stop mode");
    a_irq_single: assert property (detect_irq |=> !detect_irq [*3])
        else $error("detection interrupt repeated while flag set");
    a_event_excl: assert property (!(detect_irq && detect_reset))
        else $error("interrupt and detection reset together");

    c_irq: cover property (detect_irq);
    c_stop: cover property ($rose(stop_mode));
    c_cko: cover property (clkout_port_pin_oe);
endmodule
bind scc_top scc_top_chk u_chk (
    .clk(clk), .rst(rst), .single_chip_mode(single_chip_mode), .wait_mode(wait_mode),
    .clkout_port_pin_oe(clkout_port_pin_oe), .main_osc_out_hold_high(main_osc_out_hold_high),
    .main_osc_feedback_en(main_osc_feedback_en), .main_osc_run(main_osc_run),
    .sub_osc_pins_osc(sub_osc_pins_osc), .sub_osc_drive_high(sub_osc_drive_high),
    .cpu_clk_en(cpu_clk_en), .periph_clk_run(periph_clk_run),
    .sub_clock_div32_run(sub_clock_div32_run), .stop_mode(stop_mode),
    .detect_irq(detect_irq), .detect_reset(detect_reset));
`default_nettype wire

// *** tb/scc_top_bench.sv ***
// Register-level testbench for the system clock control block
`timescale 1ns/1ps
`default_nettype none
`include "scc_defines.svh"
module scc_top_bench
    import scc_pkg::*;
;
    logic        clk = 0, rst = 1, reg_we = 0, reg_re = 0;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0]  reg_wdata = 8'h00, reg_rdata;
    logic        single_chip_mode = 0, wait_mode = 0, main_osc_alive = 1;
    logic        sub_clock_in = 0, stop_wake = 0;
    logic        cko, cko_oe, hold_hi, fb_en, m_run, s_osc, s_flt, s_drv, m_drv;
    logic        cpu_en, p_run, s32, stop, irq, dreset;
    scc_src_t    src;
    logic        cko_prev, rst_seen = 1'b0;
    int          fails = 0, comparisons = 0;

    always #10 clk = ~clk;
    always @(posedge clk) sub_clock_in <= ~sub_clock_in;

    scc_top uut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
        .single_chip_mode(single_chip_mode), .wait_mode(wait_mode),
        .main_osc_alive(main_osc_alive), .sub_clock_in(sub_clock_in), .stop_wake(stop_wake),
        .clkout_port_pin_o(cko), .clkout_port_pin_oe(cko_oe), .main_osc_out_hold_high(hold_hi),
        .main_osc_feedback_en(fb_en), .main_osc_run(m_run), .sub_osc_pins_osc(s_osc),
        .sub_osc_pins_float(s_flt), .sub_osc_drive_high(s_drv), .main_osc_drive_high(m_drv),
        .sysclk_src(src), .cpu_clk_en(cpu_en), .periph_clk_run(p_run),
        .sub_clock_div32_run(s32), .stop_mode(stop), .detect_irq(irq), .detect_reset(dreset));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a; reg_wdata <= d; reg_we <= 1'b1;
        @(posedge clk);
        reg_we <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string what);
        @(posedge clk);
        reg_addr <= a; reg_re <= 1'b1;
        @(posedge clk);
        reg_re <= 1'b0;
        #1 chk(what, reg_rdata, exp);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Counts cpu clock enables over n cycles
    task automatic cpu_pulses(input int n, input int exp, input string what);
        int c;
        c = 0;
        repeat (n) begin
            @(posedge clk);
            #1 if (cpu_en === 1'b1) c++;
        end
        chk(what, c[7:0], exp[7:0]);
    endtask
    task automatic wait_irq(input logic exp, input string what);
        logic got;
        got = 1'b0;
        repeat (10) begin
            @(posedge clk);
            #1 if (irq === 1'b1) got = 1'b1;
            if (dreset === 1'b1) rst_seen = 1'b1;
        end
        chk(what, {7'h00, got}, {7'h00, exp});
    endtask
    task automatic complete_run;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd(`SCC_OFS_CTRL0, 8'h48, "ctrl0 reset");
        rd(`SCC_OFS_CTRL1, 8'h20, "ctrl1 reset");
        rd(16'h0003, 8'h00, "unmapped read");
        wr(`SCC_OFS_CTRL0, 8'h10);
        rd(`SCC_OFS_CTRL0, 8'h48, "ctrl0 protected");
        wr(`SCC_OFS_PROTECT, 8'h01);
        wr(`SCC_OFS_CTRL0, 8'h10);
        rd(`SCC_OFS_CTRL0, 8'h10, "ctrl0 written");
        wr(`SCC_OFS_CTRL0, 8'h00);
        rd(`SCC_OFS_CTRL0, 8'h08, "sub drive forced");
        $display("test registers done");
        wr(`SCC_OFS_CTRL0, 8'h16);
        @(posedge clk) begin single_chip_mode <= 1'b1; wait_mode <= 1'b1; end
        tick(4);
        chk("clkout enable", {7'h00, cko_oe}, 8'h01);
        chk("periph run in wait", {7'h00, p_run}, 8'h00);
        chk("sub div32 run", {7'h00, s32}, 8'h01);
        cko_prev = cko;
        tick(4);
        chk("clkout toggles", {7'h00, cko ^ cko_prev}, 8'h01);
        @(posedge clk) begin single_chip_mode <= 1'b0; wait_mode <= 1'b0; end
        tick(4);
        chk("clkout disabled", {7'h00, cko_oe}, 8'h00);
        chk("periph run", {7'h00, p_run}, 8'h01);
        cpu_pulses(8, 8, "cpu clock undivided");
        wr(`SCC_OFS_CTRL1, 8'hC0);
        cpu_pulses(32, 2, "cpu clock by 16");
        wr(`SCC_OFS_CTRL1, 8'h40);
        cpu_pulses(32, 16, "cpu clock by 2");
        $display("test clock out and wait done");
        // Lock keeps bits 2, 5, 7 of ctrl0 and bits 0, 1 of ctrl1
        wr(`SCC_OFS_MODE2, 8'h02);
        wr(`SCC_OFS_CTRL0, 8'hF2);
        rd(`SCC_OFS_CTRL0, 8'h56, "ctrl0 locked");
        cpu_pulses(16, 2, "cpu clock by 8");
        wr(`SCC_OFS_CTRL1, 8'h03);
        rd(`SCC_OFS_CTRL1, 8'h00, "ctrl1 locked");
        wr(`SCC_OFS_MODE2, 8'h04);
        wr(`SCC_OFS_CTRL1, 8'h03);
        rd(`SCC_OFS_CTRL1, 8'h02, "all stop blocked");
        wr(`SCC_OFS_CTRL1, 8'h00);
        wr(`SCC_OFS_MODE2, 8'h00);
        $display("test lock done");
        wr(`SCC_OFS_CTRL0, 8'hB0);
        rd(`SCC_OFS_CTRL0, 8'hF0, "div8 held");
        rd(`SCC_OFS_CTRL1, 8'h20, "main drive held");
        chk("main out held", {7'h00, hold_hi}, 8'h01);
        chk("main run", {7'h00, m_run}, 8'h00);
        chk("feedback kept", {7'h00, fb_en}, 8'h01);
        chk("sub pins oscillate", {7'h00, s_osc}, 8'h01);
        wr(`SCC_OFS_CTRL0, 8'h90);
        wr(`SCC_OFS_CTRL0, 8'h10);
        $display("test main stop done");
        wr(`SCC_OFS_CTRL1, 8'h00);
        wr(`SCC_OFS_CTRL1, 8'h01);
        tick(3);
        chk("stop mode", {7'h00, stop}, 8'h01);
        chk("feedback cut", {7'h00, fb_en}, 8'h00);
        chk("sub pins float", {7'h00, s_flt}, 8'h01);
        chk("sub drive on stop", {7'h00, s_drv}, 8'h01);
        chk("main drive on stop", {7'h00, m_drv}, 8'h01);
        rd(`SCC_OFS_CTRL0, 8'h58, "ctrl0 on stop");
        rd(`SCC_OFS_CTRL1, 8'h21, "ctrl1 on stop");
        @(posedge clk) stop_wake <= 1'b1;
        tick(6);
        chk("stop left", {7'h00, stop}, 8'h00);
        @(posedge clk) stop_wake <= 1'b0;
        $display("test stop done");
        wr(`SCC_OFS_DETECT, 8'h81);
        @(posedge clk) main_osc_alive <= 1'b0;
        wait_irq(1'b1, "irq on loss");
        rd(`SCC_OFS_DETECT, 8'h8F, "detect after loss");
        chk("source onchip", {6'h00, src}, {6'h00, SCC_SRC_ONCHIP});
        @(posedge clk) main_osc_alive <= 1'b1;
        wait_irq(1'b0, "irq with flag set");
        rd(`SCC_OFS_DETECT, 8'h87, "detect after restart");
        wr(`SCC_OFS_DETECT, 8'h87);
        rd(`SCC_OFS_DETECT, 8'h87, "flag write one");
        wr(`SCC_OFS_DETECT, 8'h81);
        rd(`SCC_OFS_DETECT, 8'h81, "flag cleared");
        wr(`SCC_OFS_CTRL1, 8'h22);
        tick(2);
        chk("source pll", {6'h00, src}, {6'h00, SCC_SRC_PLL});
        @(posedge clk) main_osc_alive <= 1'b0;
        wait_irq(1'b1, "irq on pll loss");
        rd(`SCC_OFS_DETECT, 8'h8D, "onchip kept");
        @(posedge clk) main_osc_alive <= 1'b1;
        tick(6);
        wr(`SCC_OFS_CTRL0, 8'h90);
        tick(2);
        chk("source sub", {6'h00, src}, {6'h00, SCC_SRC_SUB});
        chk("no detect reset", {7'h00, rst_seen}, 8'h00);
        wr(`SCC_OFS_DETECT, 8'h01);
        @(posedge clk) main_osc_alive <= 1'b0;
        wait_irq(1'b0, "no irq in reset action");
        rd(`SCC_OFS_DETECT, 8'h0D, "onchip kept on sub");
        chk("detect reset", {7'h00, rst_seen}, 8'h01);
        $display("test detection done");
        complete_run();
    end

    initial begin
        repeat (4000) @(posedge clk);
        fails++;
        complete_run();
    end
endmodule
`default_nettype wire
